// File: shared/pie_gate_if.sv
// carrier between the register block and the source gating unit
`timescale 1ns/10ps
interface pie_gate_if;
    import pie_pkg::*;

    logic [7:0]          upper;
    logic                global_en;
    logic [3:0]          gp_pin_req;
    logic                usb_req;
    logic                fifo_req;
    logic                spi_req;
    logic                hss_req;
    logic                two_wire_req;
    logic [PIE_NSRC-1:0] fwd;

    modport ctrl (
        output upper,
        output global_en,
        output gp_pin_req,
        output usb_req,
        output fifo_req,
        output spi_req,
        output hss_req,
        output two_wire_req,
        input  fwd
    );

    modport gate (
        input  upper,
        input  global_en,
        input  gp_pin_req,
        input  usb_req,
        input  fifo_req,
        input  spi_req,
        input  hss_req,
        input  two_wire_req,
        output fwd
    );
endinterface

// File: shared/pie_pkg.sv
// constants, register map and state type for the upper interrupt-enable block
package pie_pkg;

    // ------------------------------------------------------------------
    // register map (byte addresses on the apb bus)
    // ------------------------------------------------------------------
    localparam int          PIE_ADDR_W      = 12;
    localparam logic [11:0] PIE_OFF_UPPER   = 12'h000;
    localparam logic [11:0] PIE_OFF_LOWER   = 12'h004;
    localparam logic [11:0] PIE_OFF_STATUS  = 12'h008;
    localparam logic [11:0] PIE_OFF_MASK    = 12'h00C;
    localparam logic [11:0] PIE_OFF_FWD     = 12'h010;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int PIE_BIT_GP       = 7;
    localparam int PIE_BIT_USB      = 6;
    localparam int PIE_BIT_FIFO_SER = 5;
    localparam int PIE_BIT_TWO_WIRE = 4;
    localparam int PIE_BIT_GLOBAL   = 7;

    // event and forwarded-request index
    localparam int PIE_NSRC         = 4;
    localparam int PIE_EV_GP        = 0;
    localparam int PIE_EV_USB       = 1;
    localparam int PIE_EV_FIFO_SER  = 2;
    localparam int PIE_EV_TWO_WIRE  = 3;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [7:0]  PIE_UPPER_RST   = 8'h00;
    localparam logic [7:0]  PIE_LOWER_RST   = 8'h00;
    localparam logic [3:0]  PIE_SRC_RST     = 4'h0;
    localparam logic [31:0] PIE_DATA_ZERO   = 32'h0000_0000;

    typedef struct packed {
        logic [7:0]          upper;
        logic [7:0]          lower;
        logic [PIE_NSRC-1:0] status;
        logic [PIE_NSRC-1:0] mask;
        logic [PIE_NSRC-1:0] fwd;
        logic                irq;
        logic                pready;
        logic                pslverr;
        logic [31:0]         prdata;
    } pie_state_t;

    localparam pie_state_t PIE_STATE_RST = '{
        upper   : PIE_UPPER_RST,
        lower   : PIE_LOWER_RST,
        status  : PIE_SRC_RST,
        mask    : PIE_SRC_RST,
        fwd     : PIE_SRC_RST,
        irq     : 1'b0,
        pready  : 1'b0,
        pslverr : 1'b0,
        prdata  : PIE_DATA_ZERO
    };

endpackage

// File: sim/pie_top_test.sv
// self-checking testbench for the upper interrupt-enable block
`timescale 1ns/10ps
`define CHK(nm, exp, got) \
    begin \
        num_checks++; \
        if ((got) !== (exp)) \
        begin \
            error_cnt++; \
            $display("wrong value %s expected %h seen %h", nm, exp, got); \
        end \
    end
module pie_top_test;
    import pie_pkg::*;

    // ------------------------------------------------------------------
    // signals
    // ------------------------------------------------------------------
    logic        clk_sys;
    logic        resetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [8:0]  reqs;
    logic        gp_irq;
    logic        usb_irq;
    logic        fifo_serial_irq;
    logic        two_wire_irq;
    logic        irq;
    logic [31:0] rdata;
    logic        err;
    int          error_cnt;
    int          num_checks;
    int          cycles;
    wire  [3:0]  outs = {two_wire_irq, fifo_serial_irq, usb_irq, gp_irq};
    logic [11:0] offs [5] = '{PIE_OFF_UPPER, PIE_OFF_LOWER, PIE_OFF_STATUS,
                              PIE_OFF_MASK, PIE_OFF_FWD};

    pie_top i_pie_top (
        .clk_sys             (clk_sys),
        .resetn              (resetn),
        .psel                (psel),
        .penable             (penable),
        .pwrite              (pwrite),
        .paddr               (paddr),
        .pwdata              (pwdata),
        .prdata              (prdata),
        .pready              (pready),
        .pslverr             (pslverr),
        .gp_pin_a            (reqs[0]),
        .gp_pin_b            (reqs[1]),
        .gp_pin_clock_shared (reqs[2]),
        .gp_pin_d            (reqs[3]),
        .usb_irq_req         (reqs[4]),
        .fifo_irq_req        (reqs[5]),
        .spi_irq_req         (reqs[6]),
        .hss_irq_req         (reqs[7]),
        .two_wire_irq_req    (reqs[8]),
        .gp_irq              (gp_irq),
        .usb_irq             (usb_irq),
        .fifo_serial_irq     (fifo_serial_irq),
        .two_wire_irq        (two_wire_irq),
        .irq                 (irq)
    );

    // ------------------------------------------------------------------
    // clock, timeout and closing report
    // ------------------------------------------------------------------
    initial
    begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // the whole run needs well under 2000 cycles
    always @(posedge clk_sys)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            error_cnt++;
            conclude();
        end
    end

    // ------------------------------------------------------------------
    // bus and stimulus helpers
    // ------------------------------------------------------------------
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        // only the bench timeout ends a wait that never sees ready
        do
        begin
            @(posedge clk_sys);
        end
        while (pready !== 1'b1);
        rdata   = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic set_req(input logic [8:0] v);
        @(posedge clk_sys);
        reqs <= v;
    endtask

    // one edge: every forwarded output lags its cause by exactly one cycle
    task automatic settle();
        @(posedge clk_sys);
        #1;
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        for (int i = 0; i < 5; i++)
        begin
            apb(1'b0, offs[i], 32'h0000_0000);
            `CHK("reset register", 32'h0000_0000, rdata)
        end
        `CHK("outputs after reset", 5'h00, {irq, outs})
        $display("test reset done");
    endtask

    task automatic t_rw();
        apb(1'b1, PIE_OFF_UPPER, 32'h0000_00FC);
        apb(1'b0, PIE_OFF_UPPER, 32'h0000_0000);
        `CHK("upper enable", 32'h0000_00FC, rdata)
        apb(1'b1, PIE_OFF_UPPER, 32'hFFFF_FF54);
        apb(1'b0, PIE_OFF_UPPER, 32'h0000_0000);
        `CHK("upper enable", 32'h0000_0054, rdata)
        @(posedge clk_sys);
        resetn <= 1'b0;
        repeat (2) @(posedge clk_sys);
        resetn <= 1'b1;
        apb(1'b0, PIE_OFF_UPPER, 32'h0000_0000);
        `CHK("upper after reset", 32'h0000_0000, rdata)
        $display("test register access done");
    endtask

    // each single request against its own enable, the other enables, and global off
    task automatic t_gate();
        int         g;
        logic [7:0] b;
        apb(1'b1, PIE_OFF_LOWER, 32'h0000_0080);
        for (int k = 0; k < 9; k++)
        begin
            g = (k < 4) ? 0 : (k == 4) ? 1 : (k < 8) ? 2 : 3;
            b = 8'h80 >> g;
            apb(1'b1, PIE_OFF_UPPER, {24'h00_0000, b});
            set_req(9'h001 << k);
            settle();
            `CHK("forward on", 4'h1 << g, outs)
            apb(1'b1, PIE_OFF_UPPER, {24'h00_0000, ~b & 8'hFC});
            settle();
            `CHK("forward masked", 4'h0, outs)
            apb(1'b1, PIE_OFF_UPPER, {24'h00_0000, b});
            apb(1'b1, PIE_OFF_LOWER, 32'h0000_0000);
            settle();
            `CHK("global off", 4'h0, outs)
            apb(1'b1, PIE_OFF_LOWER, 32'h0000_0080);
            set_req(9'h000);
        end
        $display("test gating done");
    endtask

    task automatic t_irq();
        apb(1'b0, PIE_OFF_STATUS, 32'h0000_0000);
        apb(1'b1, PIE_OFF_MASK, 32'h0000_0002);
        apb(1'b1, PIE_OFF_UPPER, 32'h0000_0040);
        set_req(9'h010);
        settle();
        `CHK("irq usb event", 1'b1, irq)
        apb(1'b0, PIE_OFF_FWD, 32'h0000_0000);
        `CHK("forward view", 32'h0000_0002, rdata)
        apb(1'b0, PIE_OFF_STATUS, 32'h0000_0000);
        `CHK("status", 32'h0000_0002, rdata)
        settle();
        `CHK("irq after clear", 1'b0, irq)
        apb(1'b1, PIE_OFF_MASK, 32'h0000_0000);
        set_req(9'h000);
        set_req(9'h010);
        settle();
        `CHK("irq masked", 1'b0, irq)
        apb(1'b1, PIE_OFF_MASK, 32'h0000_0002);
        settle();
        `CHK("irq unmasked", 1'b1, irq)
        set_req(9'h000);
        apb(1'b0, PIE_OFF_STATUS, 32'h0000_0000);
        settle();
        `CHK("irq cleared", 1'b0, irq)
        $display("test interrupt done");
    endtask

    // unmapped offset: refused with an error, nothing stored, zero read back
    task automatic t_unmapped();
        apb(1'b1, 12'h014, 32'h0000_00FF);
        `CHK("write error", 1'b1, err)
        apb(1'b0, 12'h014, 32'h0000_0000);
        `CHK("read error", 2'b10, {err, |rdata})
        apb(1'b0, PIE_OFF_UPPER, 32'h0000_0000);
        `CHK("mapped read", 33'h0_0000_0040, {err, rdata})
        $display("test unmapped done");
    endtask

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial
    begin
        resetn     = 1'b0;
        psel       = 1'b0;
        penable    = 1'b0;
        pwrite     = 1'b0;
        paddr      = 12'h000;
        pwdata     = 32'h0000_0000;
        reqs       = 9'h000;
        error_cnt  = 0;
        num_checks = 0;
        cycles     = 0;
        repeat (16) @(posedge clk_sys);
        resetn <= 1'b1;
        t_reset();
        t_rw();
        t_gate();
        t_irq();
        t_unmapped();
        conclude();
    end
endmodule // pie_top_test

// File: verilog/pie_gate.sv
// combinational gating of each source group by its enable and the global enable
`timescale 1ns/10ps
module pie_gate
    import pie_pkg::*;
(
    pie_gate_if.gate g
);
    logic [PIE_NSRC-1:0] src;
    logic [PIE_NSRC-1:0] en;
    wire  [PIE_NSRC-1:0] gated;

    always_comb
    begin
        src                  = '0;
        en                   = '0;
        // pins arrive already qualified by their own enable and level bits
        src[PIE_EV_GP]       = |g.gp_pin_req;                         // RULE1
        en[PIE_EV_GP]        = g.upper[PIE_BIT_GP];                   // RULE1
        src[PIE_EV_USB]      = g.usb_req;                             // RULE2
        en[PIE_EV_USB]       = g.upper[PIE_BIT_USB];                  // RULE2
        src[PIE_EV_FIFO_SER] = g.fifo_req | g.spi_req | g.hss_req;    // RULE3
        en[PIE_EV_FIFO_SER]  = g.upper[PIE_BIT_FIFO_SER];             // RULE3
        src[PIE_EV_TWO_WIRE] = g.two_wire_req;                        // RULE4
        en[PIE_EV_TWO_WIRE]  = g.upper[PIE_BIT_TWO_WIRE];             // RULE4
    end

    genvar i;
    generate
        for (i = 0; i < PIE_NSRC; i++)
        begin : g_src
            assign gated[i] = src[i] & en[i] & g.global_en;           // RULE5
        end
    endgenerate

    // one driver for the whole carrier field, the bits are built on a local net
    assign g.fwd = gated;
endmodule // pie_gate

// File: verilog/pie_top.sv
// upper interrupt-enable register with apb access, source gating and event status
// Functional notes
// [RULE1] The pin-interrupt enable passes the four general-purpose pin requests, each already qualified by its own pin enable and level bits, and blocks them when clear.
// [RULE2] Enable bit 6 passes the usb request to the interrupt controller and masks it when clear.
// [RULE3] Enable bit 5 is one shared enable for the fifo, spi and high-speed serial requests.
// [RULE4] Enable bit 4 forwards the two-wire request when set and masks it when clear.
// [RULE5] The global enable bit of the lower enable register blocks every source while it is clear.
// [RULE6] Every bit of the upper enable register resets to zero and is readable and writable.
// [RULE7] Firmware always writes zero to the two lowest, reserved bits of the upper enable register.
`timescale 1ns/10ps
module pie_top
    import pie_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        resetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        gp_pin_a,
    input  wire logic        gp_pin_b,
    input  wire logic        gp_pin_clock_shared,
    input  wire logic        gp_pin_d,
    input  wire logic        usb_irq_req,
    input  wire logic        fifo_irq_req,
    input  wire logic        spi_irq_req,
    input  wire logic        hss_irq_req,
    input  wire logic        two_wire_irq_req,
    output logic             gp_irq,
    output logic             usb_irq,
    output logic             fifo_serial_irq,
    output logic             two_wire_irq,
    output logic             irq
);

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] off);
        addr_hit = (a == off);
    endfunction

    pie_state_t s_reg;
    pie_state_t s_next;
    pie_gate_if gif ();

    logic        acc_done;
    logic        wr_done;
    logic        rd_done;
    logic        mapped;
    logic [31:0] rd_val;
    logic [PIE_NSRC-1:0] ev;

    // ------------------------------------------------------------------
    // source gating
    // ------------------------------------------------------------------
    assign gif.upper        = s_reg.upper;
    assign gif.global_en    = s_reg.lower[PIE_BIT_GLOBAL];
    assign gif.gp_pin_req   = {gp_pin_d, gp_pin_clock_shared, gp_pin_b, gp_pin_a};
    assign gif.usb_req      = usb_irq_req;
    assign gif.fifo_req     = fifo_irq_req;
    assign gif.spi_req      = spi_irq_req;
    assign gif.hss_req      = hss_irq_req;
    assign gif.two_wire_req = two_wire_irq_req;

    pie_gate i_pie_gate (
        .g (gif.gate)
    );

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb
    begin
        s_next   = s_reg;
        // one wait state: pready rises on the second access cycle
        acc_done = psel & penable & s_reg.pready;
        wr_done  = acc_done & pwrite;
        rd_done  = acc_done & ~pwrite;
        mapped   = 1'b1;
        rd_val   = PIE_DATA_ZERO;

        if (addr_hit(paddr, PIE_OFF_UPPER))
        begin
            rd_val[7:0] = s_reg.upper;                                // RULE6
        end
        else if (addr_hit(paddr, PIE_OFF_LOWER))
        begin
            rd_val[7:0] = s_reg.lower;
        end
        else if (addr_hit(paddr, PIE_OFF_STATUS))
        begin
            rd_val[PIE_NSRC-1:0] = s_reg.status;
        end
        else if (addr_hit(paddr, PIE_OFF_MASK))
        begin
            rd_val[PIE_NSRC-1:0] = s_reg.mask;
        end
        else if (addr_hit(paddr, PIE_OFF_FWD))
        begin
            rd_val[PIE_NSRC-1:0] = s_reg.fwd;
        end
        else
        begin
            mapped = 1'b0;
        end

        s_next.pready  = psel & penable & ~s_reg.pready;
        s_next.pslverr = psel & penable & ~s_reg.pready & ~mapped;
        if (psel & penable & ~s_reg.pready & ~pwrite)
        begin
            s_next.prdata = rd_val;
        end
        else if (acc_done)
        begin
            s_next.prdata = PIE_DATA_ZERO;
        end

        if (wr_done)
        begin
            if (addr_hit(paddr, PIE_OFF_UPPER))
            begin
                // reserved low bits are stored as written; firmware keeps them zero
                s_next.upper = pwdata[7:0];                           // RULE6
            end
            else if (addr_hit(paddr, PIE_OFF_LOWER))
            begin
                s_next.lower = pwdata[7:0];                           // RULE5
            end
            else if (addr_hit(paddr, PIE_OFF_MASK))
            begin
                s_next.mask = pwdata[PIE_NSRC-1:0];
            end
        end

        // registered forwards to the interrupt controller
        s_next.fwd = gif.fwd;                                         // RULE1 RULE2 RULE3 RULE4
        ev         = gif.fwd & ~s_reg.fwd;

        // a status read clears, but an event in the same cycle still sets
        if (rd_done && addr_hit(paddr, PIE_OFF_STATUS))
        begin
            s_next.status = ev;
        end
        else
        begin
            s_next.status = s_reg.status | ev;
        end

        s_next.irq = |(s_next.status & s_next.mask);
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            s_reg <= PIE_STATE_RST;                                   // RULE6
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign prdata          = s_reg.prdata;
    assign pready          = s_reg.pready;
    assign pslverr         = s_reg.pslverr;
    assign gp_irq          = s_reg.fwd[PIE_EV_GP];
    assign usb_irq         = s_reg.fwd[PIE_EV_USB];
    assign fifo_serial_irq = s_reg.fwd[PIE_EV_FIFO_SER];
    assign two_wire_irq    = s_reg.fwd[PIE_EV_TWO_WIRE];
    assign irq             = s_reg.irq;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    property p_gp_gate;
        @(posedge clk_sys) disable iff (!resetn)
        $past(resetn) |-> gp_irq == ($past(s_reg.lower[PIE_BIT_GLOBAL])
            && $past(s_reg.upper[PIE_BIT_GP])
            && (|$past(gif.gp_pin_req)));
    endproperty
    a_gp_gate: assert property (p_gp_gate) else $error("pin group gating wrong"); // RULE1

    property p_usb_gate;
        @(posedge clk_sys) disable iff (!resetn)
        (usb_irq_req && !s_reg.upper[PIE_BIT_USB]) |=> !usb_irq;
    endproperty
    a_usb_gate: assert property (p_usb_gate) else $error("usb passed while disabled"); // RULE2

    property p_usb_pass;
        @(posedge clk_sys) disable iff (!resetn)
        (usb_irq_req && s_reg.upper[PIE_BIT_USB] && s_reg.lower[PIE_BIT_GLOBAL]) |=> usb_irq;
    endproperty
    a_usb_pass: assert property (p_usb_pass) else $error("usb not forwarded"); // RULE2

    property p_fifo_gate;
        @(posedge clk_sys) disable iff (!resetn)
        $past(resetn) |-> fifo_serial_irq == ($past(s_reg.upper[PIE_BIT_FIFO_SER])
            && $past(s_reg.lower[PIE_BIT_GLOBAL])
            && ($past(fifo_irq_req) || $past(spi_irq_req) || $past(hss_irq_req)));
    endproperty
    a_fifo_gate: assert property (p_fifo_gate) else $error("shared serial gating wrong"); // RULE3

    property p_two_wire_gate;
        @(posedge clk_sys) disable iff (!resetn)
        $past(resetn) |-> two_wire_irq == ($past(s_reg.upper[PIE_BIT_TWO_WIRE])
            && $past(s_reg.lower[PIE_BIT_GLOBAL]) && $past(two_wire_irq_req));
    endproperty
    a_two_wire_gate: assert property (p_two_wire_gate) else $error("two-wire gating wrong"); // RULE4

    property p_global_off;
        @(posedge clk_sys) disable iff (!resetn)
        !s_reg.lower[PIE_BIT_GLOBAL] |=> !(gp_irq || usb_irq || fifo_serial_irq || two_wire_irq);
    endproperty
    a_global_off: assert property (p_global_off) else $error("request passed with global off"); // RULE5

    property p_reset_zero;
        @(posedge clk_sys) disable iff (!resetn)
        $rose(resetn) |-> (s_reg.upper == PIE_UPPER_RST) ##1 !(usb_irq || gp_irq);
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("enable not cleared by reset"); // RULE6

    property p_upper_write;
        @(posedge clk_sys) disable iff (!resetn)
        (wr_done && addr_hit(paddr, PIE_OFF_UPPER)) |=> s_reg.upper == $past(pwdata[7:0]);
    endproperty
    a_upper_write: assert property (p_upper_write) else $error("enable write lost"); // RULE6

    // ------------------------------------------------------------------
    // bus and status assertions
    // ------------------------------------------------------------------
    property p_pready_answer;
        @(posedge clk_sys) disable iff (!resetn)
        (psel && penable && !pready) |=> pready;
    endproperty
    a_pready_answer: assert property (p_pready_answer) else $error("no ready after access");

    // the answer must not linger into a setup cycle that follows at once
    property p_pready_pulse;
        @(posedge clk_sys) disable iff (!resetn)
        pready |=> !pready;
    endproperty
    a_pready_pulse: assert property (p_pready_pulse) else $error("ready held too long");

    property p_err_with_ready;
        @(posedge clk_sys) disable iff (!resetn)
        pslverr |-> pready;
    endproperty
    a_err_with_ready: assert property (p_err_with_ready) else $error("error without ready");

    property p_err_pulse;
        @(posedge clk_sys) disable iff (!resetn)
        pslverr |=> !pslverr;
    endproperty
    a_err_pulse: assert property (p_err_pulse) else $error("error held too long");

    property p_rdata_idle;
        @(posedge clk_sys) disable iff (!resetn)
        !pready |-> prdata == PIE_DATA_ZERO;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside answer");

    property p_upper_read;
        @(posedge clk_sys) disable iff (!resetn)
        (psel && penable && !pready && !pwrite && addr_hit(paddr, PIE_OFF_UPPER))
            |=> prdata[7:0] == $past(s_reg.upper);
    endproperty
    a_upper_read: assert property (p_upper_read) else $error("enable read wrong"); // RULE6

    property p_fwd_read;
        @(posedge clk_sys) disable iff (!resetn)
        (psel && penable && !pready && !pwrite && addr_hit(paddr, PIE_OFF_FWD))
            |=> prdata[PIE_NSRC-1:0] == $past(s_reg.fwd);
    endproperty
    a_fwd_read: assert property (p_fwd_read) else $error("forward view read wrong");

    property p_unmapped_keep;
        @(posedge clk_sys) disable iff (!resetn)
        (wr_done && !mapped) |=> $stable(s_reg.upper) && $stable(s_reg.lower) && $stable(s_reg.mask);
    endproperty
    a_unmapped_keep: assert property (p_unmapped_keep) else $error("unmapped write stored");

    property p_irq_level;
        @(posedge clk_sys) disable iff (!resetn)
        irq == (|(s_reg.status & s_reg.mask));
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("irq not status and mask");

    property p_status_clear;
        @(posedge clk_sys) disable iff (!resetn)
        (rd_done && addr_hit(paddr, PIE_OFF_STATUS) && ev == PIE_SRC_RST) |=> s_reg.status == PIE_SRC_RST;
    endproperty
    a_status_clear: assert property (p_status_clear) else $error("status not cleared by read");

    // a clearing read must never swallow an event of the same cycle
    property p_event_wins;
        @(posedge clk_sys) disable iff (!resetn)
        (ev != PIE_SRC_RST) |=> (s_reg.status & $past(ev)) == $past(ev);
    endproperty
    a_event_wins: assert property (p_event_wins) else $error("event lost");

endmodule // pie_top
